// ### verilog/crosspoint_state_controller.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

module crosspoint_state_controller
    import xp_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic pready, // apb ready
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error
    output logic [`N_OUT*`PORT_W-1:0] xp_src, // input per output
    output logic [`N_OUT-1:0] xp_conn, // output connected
    output logic [`N_OUT-1:0] xp_mute, // output muted
    output logic [`N_OUT-1:0] xp_lock, // output locked
    output logic [`N_OUT-1:0] xp_active // output carries signal
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    op_mode_e mode_q;
    logic auto_q;
    port_t sel_port_q;
    logic [`N_OUT-1:0] sel_mask_q;
    logic refused_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    xp_entry_s live [`N_OUT];
    xp_entry_s eff [`N_OUT];
    logic [`N_OUT-1:0] lock_v;
    logic [`N_OUT-1:0] pend_v;
    logic [`N_OUT-1:0] fed_live;
    logic [`N_OUT-1:0] fed_eff;

    // ---------------------------------------------------------------
    // bus strobes
    // ---------------------------------------------------------------
    logic setup;
    logic wr_acc;
    logic ctrl_wr;
    logic sel_wr;
    logic cmd_wr;
    port_t arg;
    logic [5:0] slot_raw;
    logic slot_ok;
    logic [`SLOT_W-1:0] slot_idx;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign ctrl_wr = wr_acc && (paddr == `OFF_CTRL);
    assign sel_wr = wr_acc && (paddr == `OFF_SEL);
    assign cmd_wr = wr_acc && (paddr == `OFF_CMD);
    assign arg = pwdata[`CMD_ARG_LSB +: `PORT_W];
    assign slot_raw = pwdata[`CMD_SLOT_LSB +: 6];

    // preset index 1..32 mapped to 0..31
    assign slot_ok = (slot_raw != 6'h00) && (slot_raw <= 6'h20);
    assign slot_idx = slot_ok ? 5'(slot_raw - 6'h01) : 5'h00;

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    logic [`N_OUT-1:0] tgt;
    logic edit_conn;
    port_t edit_src;
    logic [`N_OUT-1:0] mute_t;
    logic [`N_OUT-1:0] lock_t;
    logic commit;
    logic cancel;
    logic auto_tgl;
    logic sel_all;
    logic desel_all;
    logic p_save;
    logic p_load;
    logic refuse;

    // one command per write, lowest bit wins
    always_comb
    begin
        tgt = '0;
        edit_conn = 1'b0;
        edit_src = '0;
        mute_t = '0;
        lock_t = '0;
        commit = 1'b0;
        cancel = 1'b0;
        auto_tgl = 1'b0;
        sel_all = 1'b0;
        desel_all = 1'b0;
        p_save = 1'b0;
        p_load = 1'b0;
        refuse = 1'b0;
        if (cmd_wr)
        begin
            if (pwdata[`CMD_CONNECT] || pwdata[`CMD_DISCONNECT])
            begin
                edit_conn = pwdata[`CMD_CONNECT];
                case (mode_q)
                    MODE_IN:
                    begin
                        // edit one output against the selected input
                        edit_src = sel_port_q;
                        tgt = `N_OUT'(8'h01 << arg);
                        tgt = edit_conn ? tgt : (tgt & fed_eff);
                    end
                    MODE_OUT:
                    begin
                        edit_src = arg;
                        tgt = sel_mask_q;
                    end
                    default:
                    begin
                        refuse = 1'b1;
                    end
                endcase
                if ((tgt == '0) || ((tgt & lock_v) != '0))
                begin
                    refuse = 1'b1;
                end
            end
            else if (pwdata[`CMD_MUTE])
            begin
                mute_t = (mode_q == MODE_OUT) ? sel_mask_q : '0;
                refuse = (mode_q != MODE_OUT);
            end
            else if (pwdata[`CMD_LOCK])
            begin
                lock_t = (mode_q == MODE_OUT) ? sel_mask_q : '0;
                refuse = (mode_q != MODE_OUT);
            end
            else if (pwdata[`CMD_SEL_ALL])
            begin
                sel_all = (mode_q == MODE_OUT);
                refuse = (mode_q != MODE_OUT);
            end
            else if (pwdata[`CMD_DESEL_ALL])
            begin
                desel_all = (mode_q == MODE_OUT);
                refuse = (mode_q != MODE_OUT);
            end
            else if (pwdata[`CMD_TAKE])
            begin
                commit = 1'b1;
            end
            else if (pwdata[`CMD_CANCEL])
            begin
                cancel = 1'b1;
            end
            else if (pwdata[`CMD_AUTO_TGL])
            begin
                auto_tgl = 1'b1;
            end
            else if (pwdata[`CMD_SAVE])
            begin
                p_save = slot_ok;
                refuse = !slot_ok;
            end
            else if (pwdata[`CMD_LOAD])
            begin
                p_load = slot_ok;
                refuse = !slot_ok;
            end
            else
            begin
                refuse = 1'b1;
            end
        end
    end

    // edits go live or to the staged holders
    logic [`N_OUT-1:0] live_we;
    logic [`N_OUT-1:0] pend_we;

    assign live_we = tgt & ~lock_v & {`N_OUT{auto_q}};
    assign pend_we = tgt & ~lock_v & {`N_OUT{~auto_q}};

    // ---------------------------------------------------------------
    // mode, commit style and selection
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            mode_q <= op_mode_e'(`RST_MODE);
        end
        else if (ctrl_wr && (pwdata[`CTRL_MODE_LSB +: 2] != 2'h3))
        begin
            mode_q <= op_mode_e'(pwdata[`CTRL_MODE_LSB +: 2]);
        end
    end

    // commit style flips only on its own command
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            auto_q <= `RST_AUTO;
        end
        else if (auto_tgl)
        begin
            auto_q <= ~auto_q;
        end
    end

    // selected port and output selection set
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sel_port_q <= '0;
            sel_mask_q <= '0;
        end
        else if (ctrl_wr)
        begin
            sel_mask_q <= '0;
        end
        else if (sel_wr)
        begin
            sel_port_q <= pwdata[`PORT_W-1:0];
            sel_mask_q <= (mode_q == MODE_OUT) ? `N_OUT'(8'h01 << pwdata[`PORT_W-1:0]) : '0;
        end
        else if (sel_all)
        begin
            sel_mask_q <= '1;
        end
        else if (desel_all)
        begin
            sel_mask_q <= '0;
        end
    end

    // outcome of the latest command
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            refused_q <= 1'b0;
        end
        else if (cmd_wr)
        begin
            refused_q <= refuse;
        end
    end

    // ---------------------------------------------------------------
    // per-output cells and presets
    // ---------------------------------------------------------------
    preset_if pif ();

    assign pif.save = p_save;
    assign pif.slot = slot_idx;

    genvar g;
    generate
        for (g = 0; g < `N_OUT; g++)
        begin : g_out
            xp_out_cell u_cell (
                .core_clk (core_clk),
                .sys_rst (sys_rst),
                .live_we (live_we[g]),
                .pend_we (pend_we[g]),
                .edit_conn (edit_conn),
                .edit_src (edit_src),
                .commit (commit),
                .cancel (cancel),
                .mute_tgl (mute_t[g]),
                .lock_tgl (lock_t[g]),
                .load_en (p_load),
                .load_ent (pif.rdata[g]),
                .live (live[g]),
                .eff (eff[g]),
                .lock (lock_v[g]),
                .pend (pend_v[g])
            );

            // snapshot for save, outputs fed by selected input
            assign pif.wdata[g] = live[g];
            assign fed_live[g] = live[g].conn && (live[g].src == sel_port_q);
            assign fed_eff[g] = eff[g].conn && (eff[g].src == sel_port_q);

            // crosspoint state outputs
            assign xp_src[g*`PORT_W +: `PORT_W] = live[g].src;
            assign xp_conn[g] = live[g].conn;
            assign xp_mute[g] = live[g].mute;
            assign xp_lock[g] = lock_v[g];
            assign xp_active[g] = live[g].conn && !live[g].mute;
        end
    endgenerate

    xp_preset_store u_store (
        .core_clk (core_clk),
        .sys_rst (sys_rst),
        .pif (pif.store)
    );

    // ---------------------------------------------------------------
    // register read, latched in the setup phase
    // ---------------------------------------------------------------
    logic [31:0] rd_d;
    logic err_d;
    logic [2:0] out_idx;

    assign out_idx = paddr[4:2];

    // reads always answered, in every mode
    always_comb
    begin
        rd_d = '0;
        err_d = 1'b0;
        if (paddr >= `OFF_OUT_BASE && paddr <= `OFF_OUT_LAST && paddr[1:0] == 2'h0)
        begin
            rd_d[`OUTF_SRC_LSB +: `PORT_W] = live[out_idx].src;
            rd_d[`OUTF_CONN_BIT] = live[out_idx].conn;
            rd_d[`OUTF_MUTE_BIT] = live[out_idx].mute;
            rd_d[`OUTF_LOCK_BIT] = lock_v[out_idx];
            rd_d[`OUTF_PEND_BIT] = pend_v[out_idx];
        end
        else
        begin
            case (paddr)
                `OFF_CTRL: rd_d[`CTRL_MODE_LSB +: 2] = mode_q;
                `OFF_SEL: rd_d[`PORT_W-1:0] = sel_port_q;
                `OFF_SELMASK: rd_d[`N_OUT-1:0] = sel_mask_q;
                `OFF_CMD: rd_d = '0;
                `OFF_STATUS:
                begin
                    rd_d[`ST_MODE_LSB +: 2] = mode_q;
                    rd_d[`ST_AUTO_BIT] = auto_q;
                    rd_d[`ST_PEND_BIT] = |pend_v;
                    rd_d[`ST_REFUSED_BIT] = refused_q;
                end
                `OFF_FED: rd_d[`N_OUT-1:0] = fed_live;
                default: err_d = 1'b1;
            endcase
        end
    end

    // read data and error held through the access phase
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= err_d;
        end
    end

    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

endmodule : crosspoint_state_controller

// ### shared/xp_defs.svh
`ifndef XP_DEFS_SVH
`define XP_DEFS_SVH

// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define N_OUT 8
`define N_IN 8
`define PORT_W 3
`define N_SLOT 32
`define SLOT_W 5

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_SEL 8'h04
`define OFF_SELMASK 8'h08
`define OFF_CMD 8'h0c
`define OFF_STATUS 8'h10
`define OFF_FED 8'h14
`define OFF_OUT_BASE 8'h20
`define OFF_OUT_LAST 8'h3c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define ST_MODE_LSB 0
`define ST_AUTO_BIT 2
`define ST_PEND_BIT 3
`define ST_REFUSED_BIT 4
`define CMD_CONNECT 0
`define CMD_DISCONNECT 1
`define CMD_MUTE 2
`define CMD_LOCK 3
`define CMD_SEL_ALL 4
`define CMD_DESEL_ALL 5
`define CMD_TAKE 6
`define CMD_CANCEL 7
`define CMD_AUTO_TGL 8
`define CMD_SAVE 9
`define CMD_LOAD 10
`define CMD_ARG_LSB 16
`define CMD_SLOT_LSB 24
`define OUTF_SRC_LSB 0
`define OUTF_CONN_BIT 3
`define OUTF_MUTE_BIT 4
`define OUTF_LOCK_BIT 5
`define OUTF_PEND_BIT 6

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define RST_MODE 2'h0
`define RST_AUTO 1'b1
`define RST_CONN 1'b0
`define RST_SRC 3'h0
`define RST_MUTE 1'b0
`define RST_LOCK 1'b0

`endif

// ### shared/xp_pkg.sv
`include "xp_defs.svh"

package xp_pkg;

    // operating modes, order gives the mode field encoding
    typedef enum logic [1:0] {
        MODE_VIEW,
        MODE_IN,
        MODE_OUT
    } op_mode_e;

    typedef logic [`PORT_W-1:0] port_t;

    // one output's routing and mute
    typedef struct packed {
        logic conn;
        port_t src;
        logic mute;
    } xp_entry_s;

    typedef xp_entry_s [`N_OUT-1:0] preset_t;

endpackage : xp_pkg

// ### shared/preset_if.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

interface preset_if;
    import xp_pkg::*;
    logic save;
    logic [`SLOT_W-1:0] slot;
    preset_t wdata;
    preset_t rdata;

    modport ctrl (output save, output slot, output wdata, input rdata);
    modport store (input save, input slot, input wdata, output rdata);
endinterface : preset_if

// ### verilog/xp_preset_store.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

module xp_preset_store
    import xp_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    preset_if.store pif // save and read port
);

    preset_t mem [`N_SLOT];

    // ---------------------------------------------------------------
    // slot memory, cleared to disconnected at reset
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int s = 0; s < `N_SLOT; s++)
            begin
                mem[s] <= '0;
            end
        end
        else if (pif.save)
        begin
            mem[pif.slot] <= pif.wdata;
        end
    end

    // read of the addressed slot
    assign pif.rdata = mem[pif.slot];

endmodule : xp_preset_store

// ### verilog/xp_out_cell.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

module xp_out_cell
    import xp_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic sys_rst, // sync reset, high
    input wire logic live_we, // immediate edit
    input wire logic pend_we, // staged edit
    input wire logic edit_conn, // 1 connect, 0 disconnect
    input wire port_t edit_src, // input for connect
    input wire logic commit, // apply staged edit
    input wire logic cancel, // drop staged edit
    input wire logic mute_tgl, // flip mute
    input wire logic lock_tgl, // flip lock
    input wire logic load_en, // preset load
    input wire xp_entry_s load_ent, // preset entry
    output xp_entry_s live, // live routing
    output xp_entry_s eff, // routing incl. staged
    output logic lock, // lock flag
    output logic pend // staged edit held
);

    xp_entry_s live_q;
    logic lock_q;
    logic pend_q;
    logic pconn_q;
    port_t psrc_q;

    // ---------------------------------------------------------------
    // live routing and mute; one source of input per output
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            live_q <= '{conn: `RST_CONN, src: `RST_SRC, mute: `RST_MUTE};
        end
        else if (load_en && !lock_q)
        begin
            live_q <= load_ent;
        end
        else if (live_we && !lock_q)
        begin
            live_q.conn <= edit_conn;
            if (edit_conn)
            begin
                live_q.src <= edit_src;
            end
        end
        else if (commit && pend_q && !lock_q)
        begin
            live_q.conn <= pconn_q;
            live_q.src <= psrc_q;
        end
        else if (mute_tgl)
        begin
            live_q.mute <= ~live_q.mute;
        end
    end

    // lock flag
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            lock_q <= `RST_LOCK;
        end
        else if (lock_tgl)
        begin
            lock_q <= ~lock_q;
        end
    end

    // staged edit holder
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            pend_q <= 1'b0;
            pconn_q <= `RST_CONN;
            psrc_q <= `RST_SRC;
        end
        else if (pend_we && !lock_q)
        begin
            pend_q <= 1'b1;
            pconn_q <= edit_conn;
            if (edit_conn)
            begin
                psrc_q <= edit_src;
            end
            else
            begin
                psrc_q <= live_q.src;
            end
        end
        else if (commit || cancel || (load_en && !lock_q))
        begin
            pend_q <= 1'b0;
        end
    end

    assign live = live_q;
    assign lock = lock_q;
    assign pend = pend_q;
    assign eff = pend_q ? xp_entry_s'{conn: pconn_q, src: psrc_q, mute: live_q.mute} : live_q;

endmodule : xp_out_cell

// ### sim/xp_properties.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

module xp_properties
    import xp_pkg::*;
(
    input wire logic core_clk, // clock
    input wire logic sys_rst, // sync reset
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic pready, // apb ready
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire logic [`N_OUT*`PORT_W-1:0] xp_src, // input per output
    input wire logic [`N_OUT-1:0] xp_conn, // connected
    input wire logic [`N_OUT-1:0] xp_mute, // muted
    input wire logic [`N_OUT-1:0] xp_lock, // locked
    input wire logic [`N_OUT-1:0] xp_active // carries signal
);
    // --------------------------------
    // access decode
    // --------------------------------
    wire logic acc = psel && penable;
    wire logic cmd_wr = acc && pwrite && (paddr == `OFF_CMD);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // --------------------------------
    // bus and crosspoint checks
    // --------------------------------
    a_ready_zero_wait: assert property (pready == acc)
        else $error("pready not zero wait");
    a_unmapped_error: assert property (acc && paddr == 8'h18 |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_active_from_mute: assert property (xp_active == (xp_conn & ~xp_mute))
        else $error("active output mismatch");
    a_route_needs_cmd: assert property (
        $changed(xp_src) || $changed(xp_conn) |-> $past(cmd_wr))
        else $error("routing changed without command");
    a_mute_needs_cmd: assert property ($changed(xp_mute) |-> $past(cmd_wr))
        else $error("mute changed without command");
    a_edit_keeps_mute: assert property (
        $past(cmd_wr && pwdata[1:0] != 2'b00) |-> $stable(xp_mute))
        else $error("edit altered mute");
    a_mute_keeps_route: assert property (
        $past(cmd_wr && pwdata[2:0] == 3'b100) |-> $stable(xp_src) && $stable(xp_lock))
        else $error("mute altered routing");
    a_lock_needs_cmd: assert property (
        $changed(xp_lock) |-> $past(cmd_wr && pwdata[3:0] == 4'b1000))
        else $error("lock changed without lock command");
    for (genvar i = 0; i < `N_OUT; i++)
    begin : g_lock
        a_lock_keeps_route: assert property (
            $past(xp_lock[i]) && xp_lock[i] |-> $stable(xp_src[3*i+:3]) && $stable(xp_conn[i]))
            else $error("locked output rerouted");
    end
    c_lock_edit: cover property (cmd_wr && pwdata[0] && (|xp_lock));
    c_mute_all: cover property (&xp_mute);
    c_slverr: cover property (acc && pslverr);
endmodule : xp_properties

// ### sim/host_model.sv
`timescale 1ns/1ps

module host_model (
    input wire logic core_clk, // clock
    input wire logic pready, // slave ready
    input wire logic [31:0] prdata, // read data
    input wire logic pslverr, // slave error
    output logic psel, // select
    output logic penable, // enable
    output logic pwrite, // direction
    output logic [7:0] paddr, // address
    output logic [31:0] pwdata // write data
);
    // idle bus at time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do
            @(posedge core_clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : host_model

// ### sim/tb.sv
`timescale 1ns/1ps
`include "xp_defs.svh"

module tb;
    import xp_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, re;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [`N_OUT*`PORT_W-1:0] xp_src;
    logic [`N_OUT-1:0] xp_conn, xp_mute, xp_lock, xp_active;
    int mismatches = 0;
    int comparisons = 0;

    host_model host_i (.core_clk(core_clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));
    crosspoint_state_controller crosspoint_state_controller_i (.core_clk(core_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .xp_src(xp_src), .xp_conn(xp_conn), .xp_mute(xp_mute),
        .xp_lock(xp_lock), .xp_active(xp_active));

    // --------------------------------
    // clock and helpers
    // --------------------------------
    initial
    begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        host_i.xfer(1'b1, a, d, rq, re);
        #1;
    endtask : w

    task automatic rd(input logic [7:0] a);
        host_i.xfer(1'b0, a, 32'h0, rq, re);
        #1;
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rq, exp);
    endtask : rdc

    task automatic cmd(input logic [31:0] d);
        w(`OFF_CMD, d);
    endtask : cmd

    task automatic give_verdict;
        if (mismatches == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    // watchdog against a hung transfer
    initial
    begin
        #8000;
        mismatches++;
        give_verdict();
    end

    // --------------------------------
    // test sequence
    // --------------------------------
    initial
    begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdc(`OFF_STATUS, 32'h4);
        cmd(32'h2000_0200);
        cmd(32'h0000_0001);
        rdc(`OFF_STATUS, 32'h14);
        chk(xp_conn, 8'h00);
        w(`OFF_CTRL, 32'h2);
        w(`OFF_SEL, 32'h1);
        cmd(32'h0005_0001);
        chk(xp_src[5:3], 3'h5);
        chk(xp_conn, 8'h02);
        cmd(32'h10);
        cmd(32'h4);
        chk(xp_mute, 8'hff);
        chk(xp_active, 8'h00);
        cmd(32'h0003_0001);
        chk(xp_src, 24'h6db6db);
        chk(xp_mute, 8'hff);
        cmd(32'h4);
        chk(xp_active, 8'hff);
        cmd(32'h0100_0200);
        cmd(32'h20);
        w(`OFF_SEL, 32'h2);
        cmd(32'h8);
        chk(xp_lock, 8'h04);
        cmd(32'h0006_0001);
        chk(xp_src[8:6], 3'h3);
        rdc(`OFF_STATUS, 32'h16);
        cmd(32'h100);
        w(`OFF_SEL, 32'h0);
        cmd(32'h0007_0001);
        chk(xp_src[2:0], 3'h3);
        rd(`OFF_OUT_BASE);
        chk(rq[6], 1'b1);
        cmd(32'h80);
        rd(`OFF_OUT_BASE);
        chk(rq[6], 1'b0);
        cmd(32'h0007_0001);
        cmd(32'h40);
        chk(xp_src[2:0], 3'h7);
        w(`OFF_CTRL, 32'h1);
        w(`OFF_CTRL, 32'h2);
        rdc(`OFF_STATUS, 32'h2);
        w(`OFF_CTRL, 32'h1);
        w(`OFF_SEL, 32'h3);
        rdc(`OFF_FED, 32'hfe);
        cmd(32'h4);
        chk(xp_mute, 8'h00);
        cmd(32'h10);
        rdc(`OFF_STATUS, 32'h11);
        cmd(32'h2000_0400);
        chk(xp_conn, 8'h04);
        chk(xp_src[8:6], 3'h3);
        chk(xp_lock, 8'h04);
        cmd(32'h0100_0400);
        chk(xp_src, 24'h6db6db);
        chk(xp_conn, 8'hff);
        cmd(32'h0000_0400);
        rdc(`OFF_STATUS, 32'h11);
        cmd(32'h100);
        cmd(32'h0001_0002);
        chk(xp_conn, 8'hfd);
        w(`OFF_SEL, 32'h5);
        cmd(32'h0001_0001);
        chk(xp_src[5:3], 3'h5);
        cmd(32'h0000_0002);
        rdc(`OFF_STATUS, 32'h15);
        chk(xp_conn, 8'hff);
        rdc(8'h18, 32'h0);
        chk(re, 1'b1);
        give_verdict();
    end
endmodule : tb

bind crosspoint_state_controller xp_properties xp_properties_i (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .xp_src(xp_src), .xp_conn(xp_conn), .xp_mute(xp_mute),
    .xp_lock(xp_lock), .xp_active(xp_active));
